// ---- include/lws_cfg.svh ----
// Offsets, fields, reset values and timing counts of the LIN support block
`ifndef LWS_CFG_SVH
`define LWS_CFG_SVH
// Register offsets
`define LWS_ADDR_CFG      8'hb4
`define LWS_ADDR_FILT     8'hb5
`define LWS_ADDR_GDLY     8'hb6
`define LWS_ADDR_WDLY     8'hb7
`define LWS_ADDR_IEN      8'hc0
`define LWS_ADDR_ISTAT    8'hc1
`define LWS_ADDR_SSW      8'hc2
// Field positions
`define LWS_CFG_FAST      0
`define LWS_CFG_PDIS      1
`define LWS_CFG_SPEN      2
`define LWS_CFG_CLR_TO    4
`define LWS_CFG_CLR_SH    5
`define LWS_IRQ_TO        2
`define LWS_IRQ_SH        3
`define LWS_IRQ_WU        4
`define LWS_SSW_TO        2
`define LWS_SSW_SH        3
// Reset values
`define LWS_RST_CFG       8'h00
`define LWS_RST_FILT      8'h0f
`define LWS_RST_GDLY      8'h4f
`define LWS_RST_WDLY      5'h14
`define LWS_RST_IEN       8'h00
// Wakeup counter idle and saturation value
`define LWS_WU_SAT        6'h20
// Timing: clock period and event times in ns
`define LWS_CLK_NS        40
`define LWS_TIMEOUT_NS    10240000
`define LWS_LP_NS         8000
// Derived cycle counts
`define LWS_TIMEOUT_CYC   (`LWS_TIMEOUT_NS / `LWS_CLK_NS)
`define LWS_LP_CYC        (`LWS_LP_NS / `LWS_CLK_NS)
// 4 MHz tick from 25 MHz: fractional accumulator step and modulus
`define LWS_F4_STEP       5'h04
`define LWS_F4_MOD        5'h19
`endif

// ---- include/lws_pkg.sv ----
// Types shared by the LIN support block
package lws_pkg;
  // Register bus data word
  typedef logic [7:0] lws_byte_type;
  // Wakeup counter
  typedef logic [5:0] lws_wcnt_type;
endpackage : lws_pkg

// ---- hw/lws_top.sv ----
// LIN wakeup, transmit stuck and bus short protection logic
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "lws_cfg.svh"

module lws_top #(
  parameter int TIMEOUT_CYCLES = `LWS_TIMEOUT_CYC,
  parameter int LP_CYCLES      = `LWS_LP_CYC
) (
  input  wire logic       CLOCK,
  input  wire logic       RST_N,
  input  wire logic       FULL_POWER_STATE,
  input  wire logic       TXD_IN,
  input  wire logic       RXD,
  input  wire logic       SHORT_IN,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  output logic            TXD_OUT,
  output logic            WAKEUP,
  output logic            LIN_FAST
);
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam int LW = $clog2(LP_CYCLES + 1);
  // Refuse counts the counters cannot serve
  generate
    if (TIMEOUT_CYCLES < 2 || LP_CYCLES < 2)
    begin : g_chk
      $error("lws_top: counts must be at least 2");
    end
  endgenerate
  // Divider state
  logic [LW-1:0] lp_cnt_r,  lp_cnt_nxt;   // 125 kHz divider
  logic          lp_tick_r, lp_tick_nxt;  // One-cycle 125 kHz enable
  logic [4:0]    f4_acc_r,  f4_acc_nxt;   // 4 MHz phase accumulator
  logic          f4_tick_r, f4_tick_nxt;  // One-cycle 4 MHz enable
  // Register state
  logic [7:0] cfg_r,  cfg_nxt;    // Bus config register
  logic [7:0] filt_r, filt_nxt;   // Short debounce setting
  logic [7:0] gdly_r, gdly_nxt;   // Short gate delay setting
  logic [4:0] wdly_r, wdly_nxt;   // Wakeup low time setting
  logic [7:0] ien_r,  ien_nxt;    // Interrupt enable vector
  logic [7:0] ist_r,  ist_nxt;    // Interrupt status vector
  logic [7:0] rdat_r, rdat_nxt;   // Read data, one cycle after strobe
  // Protection state
  lws_pkg::lws_wcnt_type wcnt_r, wcnt_nxt;  // Wakeup counter
  logic          wake_r,  wake_nxt;   // Wakeup strobe out
  logic [TW-1:0] tcnt_r,  tcnt_nxt;   // Transmit low time
  logic          stuck_r, stuck_nxt;  // Transmit stuck flag
  logic [7:0]    gcnt_r,  gcnt_nxt;   // Gate delay count
  logic          gopen_r, gopen_nxt;  // Gate opened after delay
  logic [8:0]    dcnt_r,  dcnt_nxt;   // Debounce count
  logic          short_r, short_nxt;  // Bus short flag
  logic          txd_r,   txd_nxt;    // Transmit to transceiver
  // Combinational helpers
  logic wr_cfg;      // Write to bus config register
  logic rd_ist;      // Read of the status register
  logic wu_set;      // Wakeup status set strobe
  logic to_set;      // Timeout event
  logic sh_set;      // Filtered short event
  logic gated;       // Gated short signal
  logic path_ok;     // Transmit low while receive high
  // Decodes
  assign wr_cfg  = WR && (ADDR == `LWS_ADDR_CFG);
  assign rd_ist  = RD && (ADDR == `LWS_ADDR_ISTAT);
  assign path_ok = !txd_r && RXD;
  // Gate: closed at once on tx high or rx low; a zero delay setting bypasses it
  // immediate gate close
  always_comb
  begin
    if (gdly_r == 8'h00)
      gated = SHORT_IN;
    else
      gated = SHORT_IN && path_ok && gopen_r;
  end

  // Slow enables; 4 MHz averages 4 of every 25 cycles, jitter accepted
  always_comb
  begin
    lp_tick_nxt = 1'b0;
    lp_cnt_nxt  = lp_cnt_r + LW'(1);
    if (lp_cnt_r == LW'(LP_CYCLES - 1))
    begin
      lp_cnt_nxt  = '0;
      lp_tick_nxt = 1'b1;
    end
    f4_tick_nxt = 1'b0;
    f4_acc_nxt  = f4_acc_r + `LWS_F4_STEP;
    if (f4_acc_nxt >= `LWS_F4_MOD)
    begin
      f4_acc_nxt  = f4_acc_nxt - `LWS_F4_MOD;
      f4_tick_nxt = 1'b1;
    end
  end

  // Divider registers
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      lp_cnt_r  <= '0;
      lp_tick_r <= 1'b0;
      f4_acc_r  <= 5'h00;
      f4_tick_r <= 1'b0;
    end
    else
    begin
      lp_cnt_r  <= lp_cnt_nxt;
      lp_tick_r <= lp_tick_nxt;
      f4_acc_r  <= f4_acc_nxt;
      f4_tick_r <= f4_tick_nxt;
    end
  end

  // Wakeup detection on the 125 kHz tick
  always_comb
  begin
    wcnt_nxt = wcnt_r;
    wu_set   = 1'b0;
    if (!ien_r[`LWS_IRQ_WU])
      wcnt_nxt = `LWS_WU_SAT;
    else if (lp_tick_r)
    begin
      if (RXD)
        wcnt_nxt = 6'h00;
      else if (wcnt_r != `LWS_WU_SAT)
        wcnt_nxt = wcnt_r + 6'h01;
      wu_set = (wcnt_nxt == {1'b0, wdly_r}) && (wcnt_nxt != wcnt_r);
    end
    wake_nxt = wu_set;
  end

  // Timeout in full power; one event per low stretch so a read sticks
  always_comb
  begin
    tcnt_nxt = tcnt_r;
    to_set   = 1'b0;
    if (!FULL_POWER_STATE || TXD_IN)
      tcnt_nxt = '0;
    else if (tcnt_r != TW'(TIMEOUT_CYCLES))
    begin
      tcnt_nxt = tcnt_r + TW'(1);
      to_set   = (tcnt_r == TW'(TIMEOUT_CYCLES - 1));
    end
    stuck_nxt = stuck_r;
    if (wr_cfg && WDATA[`LWS_CFG_CLR_TO])
      stuck_nxt = 1'b0;
    if (to_set)
      stuck_nxt = 1'b1;
  end

  // Short gating and debounce on the 4 MHz tick
  always_comb
  begin
    gcnt_nxt  = gcnt_r;
    gopen_nxt = gopen_r;
    if (!path_ok)
    begin
      gcnt_nxt  = 8'h00;
      gopen_nxt = 1'b0;
    end
    else if (f4_tick_r && !gopen_r)
    begin
      gcnt_nxt  = gcnt_r + 8'h01;
      gopen_nxt = (gcnt_nxt == gdly_r);
    end
    dcnt_nxt = dcnt_r;
    sh_set   = 1'b0;
    if (!gated)
      dcnt_nxt = 9'h000;
    else if (f4_tick_r && (dcnt_r <= {1'b0, filt_r}))
    begin
      dcnt_nxt = dcnt_r + 9'h001;
      sh_set   = (dcnt_r == {1'b0, filt_r});
    end
    short_nxt = short_r;
    if (wr_cfg && WDATA[`LWS_CFG_CLR_SH])
      short_nxt = 1'b0;
    if (sh_set && cfg_r[`LWS_CFG_SPEN])
      short_nxt = 1'b1;
    if (cfg_r[`LWS_CFG_PDIS])
      txd_nxt = TXD_IN;
    else
      txd_nxt = TXD_IN | stuck_r | short_r;
  end

  // Protection registers
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wcnt_r  <= `LWS_WU_SAT;
      wake_r  <= 1'b0;
      tcnt_r  <= '0;
      stuck_r <= 1'b0;
      gcnt_r  <= 8'h00;
      gopen_r <= 1'b0;
      dcnt_r  <= 9'h000;
      short_r <= 1'b0;
      txd_r   <= 1'b1;
    end
    else
    begin
      wcnt_r  <= wcnt_nxt;
      wake_r  <= wake_nxt;
      tcnt_r  <= tcnt_nxt;
      stuck_r <= stuck_nxt;
      gcnt_r  <= gcnt_nxt;
      gopen_r <= gopen_nxt;
      dcnt_r  <= dcnt_nxt;
      short_r <= short_nxt;
      txd_r   <= txd_nxt;
    end
  end

  // Register writes, status set/clear and read mux
  always_comb
  begin
    cfg_nxt  = cfg_r;
    filt_nxt = filt_r;
    gdly_nxt = gdly_r;
    wdly_nxt = wdly_r;
    ien_nxt  = ien_r;
    ist_nxt  = ist_r;
    rdat_nxt = 8'h00;
    if (WR)
    begin
      case (ADDR)
        // Clear strobes never stored
        `LWS_ADDR_CFG:  cfg_nxt  = {5'h00, WDATA[2:0]};
        `LWS_ADDR_FILT: filt_nxt = WDATA;
        `LWS_ADDR_GDLY: gdly_nxt = WDATA;
        `LWS_ADDR_WDLY: wdly_nxt = WDATA[4:0];
        `LWS_ADDR_IEN:  ien_nxt  = WDATA;
        default:        ;
      endcase
    end
    if (RD)
    begin
      case (ADDR)
        `LWS_ADDR_CFG:   rdat_nxt = cfg_r;
        `LWS_ADDR_FILT:  rdat_nxt = filt_r;
        `LWS_ADDR_GDLY:  rdat_nxt = gdly_r;
        `LWS_ADDR_WDLY:  rdat_nxt = {3'h0, wdly_r};
        `LWS_ADDR_IEN:   rdat_nxt = ien_r;
        `LWS_ADDR_ISTAT: rdat_nxt = ist_r;
        `LWS_ADDR_SSW:
          rdat_nxt = {4'h0, short_r, stuck_r, 2'b00};
        default:         rdat_nxt = 8'h00;
      endcase
    end
    if (rd_ist)
      ist_nxt = 8'h00;
    // Set beats a clear in the same cycle
    if (to_set)
      ist_nxt[`LWS_IRQ_TO] = 1'b1;
    if (sh_set)
      ist_nxt[`LWS_IRQ_SH] = 1'b1;
    if (wu_set)
      ist_nxt[`LWS_IRQ_WU] = 1'b1;
  end

  // Register file flops
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cfg_r  <= `LWS_RST_CFG;
      filt_r <= `LWS_RST_FILT;
      gdly_r <= `LWS_RST_GDLY;
      wdly_r <= `LWS_RST_WDLY;
      ien_r  <= `LWS_RST_IEN;
      ist_r  <= 8'h00;
      rdat_r <= 8'h00;
    end
    else
    begin
      cfg_r  <= cfg_nxt;
      filt_r <= filt_nxt;
      gdly_r <= gdly_nxt;
      wdly_r <= wdly_nxt;
      ien_r  <= ien_nxt;
      ist_r  <= ist_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // Outputs straight from flops
  assign RDATA    = rdat_r;
  assign TXD_OUT  = txd_r;
  assign WAKEUP   = wake_r;
  assign LIN_FAST = cfg_r[`LWS_CFG_FAST];

endmodule : lws_top

// ---- verification/lws_top_properties.sv ----
// Port checker for the LIN support block
`timescale 1ns/1ps
`include "lws_cfg.svh"
module lws_chk #(
  parameter int TIMEOUT_CYCLES = 50,
  parameter int LP_CYCLES      = 4
) (
  input wire logic       CLOCK,
  input wire logic       RST_N,
  input wire logic       FULL_POWER_STATE,
  input wire logic       TXD_IN,
  input wire logic       RXD,
  input wire logic       SHORT_IN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       TXD_OUT,
  input wire logic       WAKEUP,
  input wire logic       LIN_FAST
);
  logic pdis_r;  // Shadow of the test override bit
  logic ien_r;   // Shadow of the wakeup enable bit
  int   low_r;   // Transmit low samples in full power, saturating
  // Shadows follow software writes only
  always_ff @(posedge CLOCK or negedge RST_N)
    if (!RST_N)
    begin
      pdis_r <= 1'b0;
      ien_r  <= 1'b0;
      low_r  <= 0;
    end
    else
    begin
      if (WR && ADDR == `LWS_ADDR_CFG)
        pdis_r <= WDATA[`LWS_CFG_PDIS];
      if (WR && ADDR == `LWS_ADDR_IEN)
        ien_r <= WDATA[`LWS_IRQ_WU];
      // Same restart as the timeout; stops one past the limit
      if (!FULL_POWER_STATE || TXD_IN)
        low_r <= 0;
      else if (low_r <= TIMEOUT_CYCLES)
        low_r <= low_r + 1;
    end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Read request at a given offset
  sequence s_read(logic [7:0] a);
    RD && ADDR == a;
  endsequence
  chk_txd_follow: assert property (TXD_IN |=> TXD_OUT)
    else $error("transmit output low while input high");
  chk_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data not zero outside a read");
  chk_override_pass: assert property ((pdis_r && !TXD_IN) |=> !TXD_OUT)
    else $error("transmit forced high under override");
  chk_wake_pulse: assert property (WAKEUP |=> !WAKEUP)
    else $error("wakeup longer than one cycle");
  chk_wake_off: assert property (!ien_r [*3] |-> !WAKEUP)
    else $error("wakeup while disabled");
  chk_ssw_spare: assert property (s_read(`LWS_ADDR_SSW) |=>
    RDATA[7:4] == 4'h0 && RDATA[1:0] == 2'h0)
    else $error("status word spare bits set");
  chk_strobe_read: assert property (s_read(`LWS_ADDR_CFG) |=>
    RDATA[7:3] == 5'h00)
    else $error("clear strobes read back nonzero");
  chk_stuck_force: assert property (
    (low_r == TIMEOUT_CYCLES && !pdis_r) |=> TXD_OUT)
    else $error("transmit not forced after timeout");
endmodule : lws_chk
bind lws_top lws_chk #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
  .LP_CYCLES     (LP_CYCLES)
) u_chk (
  .CLOCK(CLOCK), .RST_N(RST_N), .FULL_POWER_STATE(FULL_POWER_STATE),
  .TXD_IN(TXD_IN), .RXD(RXD), .SHORT_IN(SHORT_IN), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TXD_OUT(TXD_OUT),
  .WAKEUP(WAKEUP), .LIN_FAST(LIN_FAST)
);

// ---- verification/lws_far_end.sv ----
// Microcontroller, transceiver and bus seen from the block
`timescale 1ns/1ps
module lws_far_end (
  input  wire logic txd_out,    // Transmit reaching the transceiver
  input  wire logic force_low,  // Commanded stuck controller fault
  input  wire logic wake_low,   // Remote master holds bus dominant
  input  wire logic short_on,   // Bus shorted to battery
  output logic      txd_in,     // Controller transmit line
  output logic      rxd,        // Receive echo of the bus
  output logic      short_in    // Transceiver overcurrent signal
);
  // idle recessive
  // Controller stays recessive unless the fault is commanded
  assign txd_in = !force_low;
  // Pulled-up bus; a battery short keeps it high
  assign rxd = short_on | (txd_out & !wake_low);
  // Overcurrent may also come from disturbances, so not gated here
  assign short_in = short_on;
endmodule : lws_far_end

// ---- verification/tb_top.sv ----
// Self-checking bench for the LIN support block
`timescale 1ns/1ps
module tb_top;
  logic       CLOCK = 1'b0;  // 25 MHz clock
  logic       RST_N = 1'b0;  // Reset, active low
  logic       FULL_POWER_STATE = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic       WR = 1'b0;
  logic       RD = 1'b0;
  logic       force_low = 1'b0;  // Stuck controller command
  logic       wake_low = 1'b0;   // Wakeup frame command
  logic       short_on = 1'b0;   // Battery short command
  logic       woke = 1'b0;       // Wakeup pulse seen
  logic       txd_in, rxd, short_in, txd_out, wakeup, lin_fast;
  logic [7:0] rdata;
  int         n_mismatch = 0;
  int         checked = 0;
  int         cyc = 0;
  always #20 CLOCK = ~CLOCK;
  lws_top #(.TIMEOUT_CYCLES(50), .LP_CYCLES(4)) uut (
    .CLOCK(CLOCK), .RST_N(RST_N), .FULL_POWER_STATE(FULL_POWER_STATE),
    .TXD_IN(txd_in), .RXD(rxd), .SHORT_IN(short_in), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(rdata), .TXD_OUT(txd_out),
    .WAKEUP(wakeup), .LIN_FAST(lin_fast));
  lws_far_end u_far (.txd_out(txd_out), .force_low(force_low),
    .wake_low(wake_low), .short_on(short_on), .txd_in(txd_in),
    .rxd(rxd), .short_in(short_in));
  // Ends the run with the verdict
  task close_out;
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One-cycle write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask : wr
  // One-cycle read, data taken in the following cycle
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLOCK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rc
  // Latch wakeup pulses; hang guard well above the expected run
  always @(posedge CLOCK)
  begin
    cyc <= cyc + 1;
    if (wakeup === 1'b1)
      woke <= 1'b1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  initial
  begin
    repeat (6) @(posedge CLOCK);
    RST_N <= 1'b1;
    rc(8'hb4, 8'h00);
    rc(8'hb5, 8'h0f);
    rc(8'hb6, 8'h4f);
    rc(8'hb7, 8'h14);
    rc(8'hc0, 8'h00);
    rc(8'hc2, 8'h00);
    rc(8'h33, 8'h00);
    chk({7'h00, lin_fast}, 8'h00);
    // Disabled wakeup ignores a long low
    // setting never zero
    wake_low <= 1'b1;
    repeat (120) @(posedge CLOCK);
    rc(8'hc1, 8'h00);
    wake_low <= 1'b0;
    wr(8'hc0, 8'h10);
    repeat (10) @(posedge CLOCK);
    wake_low <= 1'b1;
    repeat (40) @(posedge CLOCK);
    wake_low <= 1'b0;
    rc(8'hc1, 8'h00);
    repeat (10) @(posedge CLOCK);
    wake_low <= 1'b1;
    repeat (120) @(posedge CLOCK);
    rc(8'hc1, 8'h10);
    chk({7'h00, woke}, 8'h01);
    wake_low <= 1'b0;
    wr(8'hc0, 8'h00);
    // Stuck transmit in full power
    force_low <= 1'b1;
    repeat (60) @(posedge CLOCK);
    rc(8'hc2, 8'h04);
    chk({7'h00, txd_out}, 8'h01);
    rc(8'hc1, 8'h04);
    rc(8'hc1, 8'h00);
    rc(8'hc2, 8'h04);
    force_low <= 1'b0;
    wr(8'hb4, 8'h10);
    rc(8'hc2, 8'h00);
    // Override lets a stuck low through
    wr(8'hb4, 8'h02);
    force_low <= 1'b1;
    repeat (70) @(posedge CLOCK);
    rc(8'hc2, 8'h04);
    chk({7'h00, txd_out}, 8'h00);
    force_low <= 1'b0;
    wr(8'hb4, 8'h10);
    rc(8'hc1, 8'h04);
    // Zero gate delay passes a short with transmit high
    wr(8'hb6, 8'h00);
    short_on <= 1'b1;
    repeat (150) @(posedge CLOCK);
    short_on <= 1'b0;
    rc(8'hc1, 8'h08);
    rc(8'hc2, 8'h00);
    // Gated short with protection on, outside full power
    wr(8'hb6, 8'h4f);
    FULL_POWER_STATE <= 1'b0;
    wr(8'hb4, 8'h04);
    force_low <= 1'b1;
    short_on <= 1'b1;
    repeat (300) @(posedge CLOCK);
    rc(8'hc1, 8'h00);
    repeat (500) @(posedge CLOCK);
    rc(8'hc1, 8'h08);
    rc(8'hc2, 8'h08);
    chk({7'h00, txd_out}, 8'h01);
    short_on <= 1'b0;
    force_low <= 1'b0;
    repeat (5) @(posedge CLOCK);
    rc(8'hc2, 8'h08);
    wr(8'hb4, 8'h24);
    rc(8'hc2, 8'h00);
    // Nonzero delay keeps a short out while transmit is high
    short_on <= 1'b1;
    repeat (150) @(posedge CLOCK);
    rc(8'hc1, 8'h00);
    short_on <= 1'b0;
    // Fast slew bit reaches its pin
    wr(8'hb4, 8'h01);
    rc(8'hb4, 8'h01);
    chk({7'h00, lin_fast}, 8'h01);
    close_out();
  end
endmodule : tb_top
